// *** logic/ebp_bit_engine.sv ***
// Slot-level bit engine: reset, write, read and program-pulse slots
module ebp_bit_engine (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // Request
    input  wire logic           start,
    input  ebp_pkg::ebp_op_e    op,
    input  wire logic           wrBit,
    output logic                busy,
    output logic                done,
    output logic                rdBit,
    // Line
    input  wire logic           lineIn,
    output logic                lineOe,
    output logic                progOe
);
    typedef enum logic [1:0] { ST_IDLE, ST_LOW, ST_WAIT } ebp_bstate_e;

    ebp_bstate_e       state,  next_state;
    ebp_pkg::ebp_op_e  curOp,  next_curOp;
    logic              curBit, next_curBit;
    logic [20:0]       cnt,    next_cnt;
    logic              rdBitQ, next_rdBit;
    logic              doneQ,  next_done;

    assign busy  = (state != ST_IDLE);
    assign done  = doneQ;
    assign rdBit = rdBitQ;

    // Line is only pulled low here; the pullup makes the high level
    // R17 released line idles high
    always_comb begin
        lineOe = 1'b0;
        progOe = 1'b0;
        if (state == ST_LOW) begin
            if (curOp == ebp_pkg::EBP_OP_PROG) begin
                progOe = 1'b1;
            end else begin
                lineOe = 1'b1;
            end
        end
    end

    // Slot sequencing
    always_comb begin
        next_state  = state;
        next_curOp  = curOp;
        next_curBit = curBit;
        next_cnt    = cnt + 21'd1;
        next_rdBit  = rdBitQ;
        next_done   = 1'b0;
        case (state)
            ST_IDLE: begin
                next_cnt = '0;
                if (start) begin
                    next_curOp  = op;
                    next_curBit = wrBit;
                    next_state  = ST_LOW;
                end
            end
            ST_LOW: begin
                // R16 slot start edge
                case (curOp)
                    ebp_pkg::EBP_OP_RESET: if (cnt == 21'(ebp_pkg::RESET_LOW_CYC - 1)) next_state = ST_WAIT;
                    ebp_pkg::EBP_OP_PROG:  if (cnt == 21'(ebp_pkg::PROG_CYC - 1)) next_state = ST_WAIT;
                    ebp_pkg::EBP_OP_WRITE: begin
                        if (cnt == (curBit ? 21'(ebp_pkg::LOW_SHORT_CYC - 1) : 21'(ebp_pkg::LOW_WR0_CYC - 1))) begin
                            next_state = ST_WAIT;
                        end
                    end
                    default: if (cnt == 21'(ebp_pkg::LOW_SHORT_CYC - 1)) next_state = ST_WAIT;
                endcase
            end
            ST_WAIT: begin
                if (curOp == ebp_pkg::EBP_OP_READ && cnt == 21'(ebp_pkg::SAMPLE_CYC)) begin
                    next_rdBit = lineIn;
                end
                if (curOp == ebp_pkg::EBP_OP_RESET && cnt == 21'(ebp_pkg::RESET_LOW_CYC + ebp_pkg::PRES_SAMP_CYC)) begin
                    next_rdBit = ~lineIn;
                end
                // R18 slot length caps rate
                if ((curOp == ebp_pkg::EBP_OP_RESET &&
                     cnt >= 21'(ebp_pkg::RESET_LOW_CYC + ebp_pkg::PRES_WAIT_CYC)) ||
                    (curOp == ebp_pkg::EBP_OP_PROG &&
                     cnt >= 21'(ebp_pkg::PROG_CYC + ebp_pkg::RECOVER_CYC)) ||
                    ((curOp == ebp_pkg::EBP_OP_READ || curOp == ebp_pkg::EBP_OP_WRITE) &&
                     cnt >= 21'(ebp_pkg::SLOT_CYC + ebp_pkg::RECOVER_CYC))) begin
                    next_state = ST_IDLE;
                    next_done  = 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state  <= ST_IDLE;
            curOp  <= ebp_pkg::EBP_OP_RESET;
            curBit <= 1'b1;
            cnt    <= '0;
            rdBitQ <= 1'b1;
            doneQ  <= 1'b0;
        end else begin
            state  <= next_state;
            curOp  <= next_curOp;
            curBit <= next_curBit;
            cnt    <= next_cnt;
            rdBitQ <= next_rdBit;
            doneQ  <= next_done;
        end
    end

endmodule : ebp_bit_engine

// *** logic/ebp_pkg.sv ***
package ebp_pkg;

    // Command codes
    localparam logic [7:0] CMD_WRITE_DATA   = 8'h0F;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h55;
    localparam logic [7:0] CMD_SKIP_SELECT  = 8'hCC;

    // Clock rate and timings
    localparam int CLK_HZ       = 40_000_000;
    localparam int RESET_LOW_US = 480;
    localparam int PRES_WAIT_US = 480;
    localparam int PROG_US      = 480;
    localparam int SLOT_US      = 65;
    localparam int LOW_WR0_US   = 60;
    localparam int LOW_SHORT_US = 2;
    localparam int SAMPLE_US    = 13;
    localparam int PRES_SAMP_US = 70;
    localparam int RECOVER_US   = 5;

    localparam int RESET_LOW_CYC = (RESET_LOW_US * (CLK_HZ / 1_000_000));
    localparam int PRES_WAIT_CYC = (PRES_WAIT_US * (CLK_HZ / 1_000_000));
    localparam int PROG_CYC      = (PROG_US * (CLK_HZ / 1_000_000));
    localparam int SLOT_CYC      = (SLOT_US * (CLK_HZ / 1_000_000));
    localparam int LOW_WR0_CYC   = (LOW_WR0_US * (CLK_HZ / 1_000_000));
    localparam int LOW_SHORT_CYC = (LOW_SHORT_US * (CLK_HZ / 1_000_000));
    localparam int SAMPLE_CYC    = (SAMPLE_US * (CLK_HZ / 1_000_000));
    localparam int PRES_SAMP_CYC = (PRES_SAMP_US * (CLK_HZ / 1_000_000));
    localparam int RECOVER_CYC   = (RECOVER_US * (CLK_HZ / 1_000_000));

    localparam int ADDR_MAX_DATA = 16'h007F;
    localparam int CNT_W         = 16;

    // Bit engine operations
    typedef enum logic [1:0] {
        EBP_OP_RESET,
        EBP_OP_WRITE,
        EBP_OP_READ,
        EBP_OP_PROG
    } ebp_op_e;

    // One job request from the user
    typedef struct packed {
        logic        status;
        logic [15:0] address;
        logic [7:0]  data;
        logic        first;
    } ebp_job_s;

    // Outcome of one programmed byte
    typedef struct packed {
        logic [7:0] crcDevice;
        logic [7:0] crcLocal;
        logic [7:0] verify;
        logic       crcOk;
        logic       verifyOk;
        logic       noPresence;
    } ebp_result_s;

    // Reflected CRC step, polynomial x^8 + x^5 + x^4 + 1
    function automatic logic [7:0] crc_bit(input logic [7:0] crc, input logic b);
        logic fb;
        fb = crc[0] ^ b;
        crc_bit = {fb, crc[7:1]} ^ (fb ? 8'h0C : 8'h00);
    endfunction : crc_bit

    function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = crc_bit(c, d[i]);
        end
        crc_byte = c;
    endfunction : crc_byte

endpackage : ebp_pkg

// *** logic/ebp_sequencer.sv ***
// Operation
// R01: Data command 0Fh, address low, high, data
// R02: Device returns CRC over command, address, data
// R03: Data start above 007Fh gives CRC mismatch
// R04: Bad CRC: reset and redo; good: pulse
// R05: Program clears zero bits only
// R06: Eight verify reads return stored byte
// R07: Verify mismatch: reset and reprogram address; code only flags verifyOk and ends the job
// R08: Device increments address after verify
// R09: Next CRC seeds with new address low
// R10: Later bytes: data, CRC check, pulse
// R11: Device programs on any pulse
// R12: Reset pulse abandons command
// R13: Status command 55h, same flow
// R14: Status bytes ones, eighth fixed 00h
// R15: Status address advances, CRC preloaded
// R16: Single master starts every slot
// R17: Line idles high, low over 120us resets
// R18: Rate at most 16.3 kbit/s
// R19: All bits least significant first
// R20: CRC polynomial x^8+x^5+x^4+1
// R21: Device waits for new initialization
module ebp_sequencer (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Job request
    input  wire logic                  jobValid,
    input  ebp_pkg::ebp_job_s          job,
    output logic                       jobReady,
    // Result
    output logic                       resValid,
    output ebp_pkg::ebp_result_s       result,
    // Line: open drain low and 12 V switch
    input  wire logic                  lineIn,
    output logic                       lineOe,
    output logic                       progOe
);
    typedef enum logic [3:0] {
        S_IDLE, S_RST, S_ROM, S_CMD, S_ADL, S_ADH, S_DATA,
        S_CRC, S_PROG, S_VER, S_DONE
    } ebp_state_e;

    ebp_state_e           state,   next_state;
    ebp_pkg::ebp_job_s    cur,     next_cur;
    logic [7:0]           sh,      next_sh;
    logic [2:0]           bitIdx,  next_bitIdx;
    logic [7:0]           crcL,    next_crcL;
    logic                 issued,  next_issued;
    ebp_pkg::ebp_result_s res,     next_res;
    logic                 resV,    next_resV;

    logic                 engStart;
    ebp_pkg::ebp_op_e     engOp;
    logic                 engWr;
    logic                 engBusy;
    logic                 engDone;
    logic                 engRd;
    logic [7:0]           txByte;

    ebp_bit_engine u_ebp_bit_engine (
        .clk    (clk),
        .rst    (rst),
        .start  (engStart),
        .op     (engOp),
        .wrBit  (engWr),
        .busy   (engBusy),
        .done   (engDone),
        .rdBit  (engRd),
        .lineIn (lineIn),
        .lineOe (lineOe),
        .progOe (progOe)
    );

    assign jobReady = (state == S_IDLE);
    assign resValid = resV;
    assign result   = res;

    // Byte to send in each transmit state, command per field
    function automatic logic [7:0] tx_byte(input ebp_state_e s, input ebp_pkg::ebp_job_s j);
        case (s)
            // R01 data command
            // R13 status command
            S_CMD:   tx_byte = j.status ? ebp_pkg::CMD_WRITE_STATUS : ebp_pkg::CMD_WRITE_DATA;
            S_ADL:   tx_byte = j.address[7:0];
            S_ADH:   tx_byte = j.address[15:8];
            S_DATA:  tx_byte = j.data;
            S_ROM:   tx_byte = ebp_pkg::CMD_SKIP_SELECT;
            default: tx_byte = 8'hFF;
        endcase
    endfunction : tx_byte

    function automatic logic is_tx(input ebp_state_e s);
        is_tx = (s == S_ROM || s == S_CMD || s == S_ADL || s == S_ADH || s == S_DATA);
    endfunction : is_tx

    // Engine request: one slot issued per state step
    always_comb begin
        engStart = 1'b0;
        engOp    = ebp_pkg::EBP_OP_WRITE;
        // Held in a variable: a call result cannot be bit-selected directly
        txByte   = tx_byte(state, cur);
        // R19 LSB first
        engWr    = txByte[bitIdx];
        if (!issued && !engBusy && !engDone) begin
            case (state)
                S_RST:  begin engStart = 1'b1; engOp = ebp_pkg::EBP_OP_RESET; end
                S_PROG: begin engStart = 1'b1; engOp = ebp_pkg::EBP_OP_PROG;  end
                S_CRC, S_VER: begin engStart = 1'b1; engOp = ebp_pkg::EBP_OP_READ; end
                default: engStart = is_tx(state);
            endcase
        end
    end

    // Transaction flow
    always_comb begin
        next_state  = state;
        next_cur    = cur;
        next_sh     = sh;
        next_bitIdx = bitIdx;
        next_crcL   = crcL;
        next_issued = issued;
        next_res    = res;
        next_resV   = 1'b0;
        if (engStart) begin
            next_issued = 1'b1;
        end
        case (state)
            S_IDLE: begin
                if (jobValid) begin
                    next_cur    = job;
                    next_res    = '0;
                    next_bitIdx = '0;
                    // R09 seed from new address low
                    // R15 same seed for status field
                    next_crcL   = job.address[7:0];
                    next_state  = job.first ? S_RST : S_DATA;
                end
            end
            S_DONE: next_state = S_IDLE;
            default: begin
                if (engDone) begin
                    next_issued = 1'b0;
                    next_bitIdx = bitIdx + 3'd1;
                    next_sh     = {engRd, sh[7:1]};
                    // R20 local CRC
                    if (state == S_CMD || state == S_ADL || state == S_ADH || state == S_DATA) begin
                        next_crcL = ebp_pkg::crc_bit(crcL, engWr);
                    end
                    if (state == S_CMD && bitIdx == 3'd0) begin
                        // R02 full pass starts at zero
                        next_crcL = ebp_pkg::crc_bit(8'h00, engWr);
                    end
                    case (state)
                        S_RST: begin
                            next_bitIdx = '0;
                            // R12 reset opens a fresh command
                            if (!engRd) begin
                                next_res.noPresence = 1'b1;
                                next_resV           = 1'b1;
                                next_state          = S_DONE;
                            end else begin
                                next_state = S_ROM;
                            end
                        end
                        S_PROG: begin
                            next_bitIdx = '0;
                            next_state  = S_VER;
                        end
                        default: begin
                            if (bitIdx == 3'd7) begin
                                case (state)
                                    S_ROM:  next_state = S_CMD;
                                    S_CMD:  next_state = S_ADL;
                                    S_ADL:  next_state = S_ADH;
                                    S_ADH:  next_state = S_DATA;
                                    S_DATA: next_state = S_CRC;
                                    S_CRC: begin
                                        next_res.crcDevice = {engRd, sh[7:1]};
                                        next_res.crcLocal  = crcL;
                                        next_res.crcOk     = ({engRd, sh[7:1]} == crcL);
                                        // R04 pulse only on good CRC
                                        // R10 later bytes same check
                                        // R03 high address shows as mismatch
                                        if ({engRd, sh[7:1]} == crcL) begin
                                            next_state = S_PROG;
                                        end else begin
                                            next_resV  = 1'b1;
                                            next_state = S_RST;
                                        end
                                    end
                                    S_VER: begin
                                        // R06 verify byte
                                        // R07 bits still one mean failure
                                        next_res.verify   = {engRd, sh[7:1]};
                                        next_res.verifyOk = (({engRd, sh[7:1]} & ~cur.data) == 8'h00);
                                        next_resV         = 1'b1;
                                        next_state        = S_DONE;
                                    end
                                    default: next_state = S_IDLE;
                                endcase
                            end
                        end
                    endcase
                end
            end
        endcase
        // After a CRC failure, retry from reset with a full pass
        if (state == S_CRC && next_state == S_RST) begin
            next_cur.first = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state  <= S_IDLE;
            cur    <= '0;
            sh     <= '0;
            bitIdx <= '0;
            crcL   <= '0;
            issued <= 1'b0;
            res    <= '0;
            resV   <= 1'b0;
        end else begin
            state  <= next_state;
            cur    <= next_cur;
            sh     <= next_sh;
            bitIdx <= next_bitIdx;
            crcL   <= next_crcL;
            issued <= next_issued;
            res    <= next_res;
            resV   <= next_resV;
        end
    end

endmodule : ebp_sequencer

// *** tb/ebp_dev_model.sv ***
module ebp_dev_model (
    // Bus side
    input  wire logic lineOe,
    input  wire logic progOe,
    // Faults the bench may order
    input  wire logic badCrc,
    input  wire logic absent,
    output logic      devPull
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0]  dataMem [128];
    logic [7:0]  statMem [8];
    logic [7:0]  cmd;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  dat;
    logic [7:0]  crc;
    logic [15:0] addr;
    logic        woke = 1'b0;
    time         tLow = 0;
    wire logic   line = !(lineOe || devPull);

    // blank ones, last status byte 00h
    initial begin
        devPull = 1'b0;
        foreach (dataMem[i]) dataMem[i] = 8'hFF;
        foreach (statMem[i]) statMem[i] = (i == 7) ? 8'h00 : 8'hFF;
    end

    always @(negedge line) tLow = $time;
    always @(posedge line) begin
        if ($time - tLow > 400_000) begin
            disable run;
            devPull = 1'b0;
            woke = 1'b1;
        end
    end

    task automatic rx(output logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge line);
            #15000;
            b[i] = line;
        end
    endtask : rx

    task automatic tx(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge line);
            devPull = !b[i];
            #30000;
            devPull = 1'b0;
        end
    endtask : tx

    // Command flow; a wrong code just waits for the next reset
    initial forever begin : run
        wait (woke);
        woke = 1'b0;
        #30000;
        devPull = !absent;
        #120000;
        devPull = 1'b0;
        rx(cmd);
        if (cmd != 8'hCC) wait (woke);
        rx(cmd);
        rx(lo);
        rx(hi);
        rx(dat);
        if (cmd != 8'h0F && cmd != 8'h55) wait (woke);
        addr = (cmd == 8'h0F) ? ({hi, lo} & 16'h007F) : {hi, lo};
        crc = ebp_tb_pkg::crc8(8'h00, {dat, addr, cmd}, 4);
        forever begin
            tx(badCrc ? ~crc : crc);
            @(negedge progOe);
            if (cmd == 8'h0F) dataMem[addr[6:0]] &= dat;
            else statMem[addr[2:0]] &= dat;
            tx((cmd == 8'h0F) ? dataMem[addr[6:0]] : statMem[addr[2:0]]);
            addr = addr + 16'h0001;
            rx(dat);
            crc = ebp_tb_pkg::crc8(addr[7:0], {24'h000000, dat}, 1);
        end
    end

endmodule : ebp_dev_model

// *** tb/ebp_sequencer_assertions.sv ***
module ebp_sequencer_assertions (
    // Clock and reset
    input wire logic            clk,
    input wire logic            rst,
    // Job and result
    input wire logic            jobValid,
    input ebp_pkg::ebp_job_s    job,
    input wire logic            jobReady,
    input wire logic            resValid,
    input ebp_pkg::ebp_result_s result,
    // Line
    input wire logic            lineIn,
    input wire logic            lineOe,
    input wire logic            progOe
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [15:0] lowCnt;
    logic [15:0] progCnt;
    logic [15:0] next_lowCnt;
    logic [15:0] next_progCnt;

    // Run lengths of each drive; longest is far below the width
    always_comb begin
        next_lowCnt  = lineOe ? lowCnt + 16'h0001 : 16'h0000;
        next_progCnt = progOe ? progCnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk) begin
        lowCnt  <= rst ? 16'h0000 : next_lowCnt;
        progCnt <= rst ? 16'h0000 : next_progCnt;
    end

    sequence s_taken;
        jobValid && jobReady;
    endsequence
    sequence s_idle;
        !lineOe && !progOe;
    endsequence

    property p_rstIdle;
        disable iff (1'b0) rst |=> s_idle and (jobReady && !resValid);
    endproperty
    property p_taken;    s_taken |=> !jobReady; endproperty
    property p_idleLine; jobReady |-> s_idle; endproperty
    property p_noFight;  progOe |-> !lineOe; endproperty
    property p_slotLow;
        $fell(lineOe) |-> lowCnt inside {[16'd78:16'd82], [16'd2398:16'd2402], [16'd19198:16'd19202]};
    endproperty
    property p_lowMax;   lineOe |-> lowCnt <= 16'd19202; endproperty
    property p_progLen;  $fell(progOe) |-> progCnt inside {[16'd19198:16'd19202]}; endproperty
    property p_resPulse; resValid |=> !resValid; endproperty
    // A failed CRC must be followed at once by a fresh reset pulse
    property p_crcRetry;
        resValid && !result.crcOk && !result.noPresence |=> lineOe;
    endproperty
    // Result may move while a job runs, but stands while idle
    property p_stand;    jobReady |-> $stable(result); endproperty

    a_rstIdle:  assert property (p_rstIdle)  else $error("line not idle around reset");
    a_taken:    assert property (p_taken)    else $error("ready after job taken");
    a_idleLine: assert property (p_idleLine) else $error("line driven while idle");
    a_noFight:  assert property (p_noFight)  else $error("pull low during pulse");
    a_slotLow:  assert property (p_slotLow)  else $error("low time off");
    a_lowMax:   assert property (p_lowMax)   else $error("line low too long");
    a_progLen:  assert property (p_progLen)  else $error("program pulse length");
    a_resPulse: assert property (p_resPulse) else $error("result valid too long");
    a_crcRetry: assert property (p_crcRetry) else $error("no reset after bad crc");
    a_stand:    assert property (p_stand)    else $error("result changed while idle");

endmodule : ebp_sequencer_assertions

bind ebp_sequencer ebp_sequencer_assertions u_ebp_sequencer_assertions (
    .clk, .rst, .jobValid, .job, .jobReady, .resValid, .result, .lineIn, .lineOe, .progOe
);

// *** tb/ebp_tb_pkg.sv ***
package ebp_tb_pkg;

    function automatic logic [7:0] crc8(input logic [7:0] init, input logic [31:0] v, input int n);
        logic [7:0] c;
        c = init;
        for (int i = 0; i < 8 * n; i++) begin
            c = (c[0] ^ v[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
        end
        return c;
    endfunction : crc8

endpackage : ebp_tb_pkg

// *** tb/test_ebp_sequencer.sv ***
module test_ebp_sequencer;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LIMIT = 2_600_000;
    logic                 clk;
    logic                 rst;
    logic                 jobValid;
    logic                 jobReady;
    logic                 resValid;
    logic                 lineOe;
    logic                 progOe;
    logic                 devPull;
    logic                 badCrc;
    logic                 absent;
    ebp_pkg::ebp_job_s    job;
    ebp_pkg::ebp_result_s result;
    ebp_pkg::ebp_result_s expQ [$];
    int                   modeQ [$];
    logic [7:0]           dataShadow [128];
    logic [7:0]           statShadow [8];
    logic [15:0]          lfsr = 16'hF2CC;
    int                   err_count = 0;
    int                   tests_run = 0;
    int                   cycles = 0;
    wire logic            lineIn = !(lineOe || devPull);

    ebp_sequencer u_ebp_sequencer (.clk(clk), .rst(rst), .jobValid(jobValid), .job(job), .jobReady(jobReady),
        .resValid(resValid), .result(result), .lineIn(lineIn), .lineOe(lineOe), .progOe(progOe));
    ebp_dev_model u_ebp_dev_model (.lineOe(lineOe), .progOe(progOe), .badCrc(badCrc), .absent(absent),
        .devPull(devPull));

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    // Expected outcome; the bench's shadow only changes when a pulse follows
    task automatic expect_res(input logic st, input logic [15:0] ad, input logic [7:0] d, input logic fst);
        ebp_pkg::ebp_result_s e;
        logic [15:0]          da;
        da = st ? ad : (ad & 16'h007F);
        e.crcLocal = fst ? ebp_tb_pkg::crc8(8'h00, {d, ad, st ? 8'h55 : 8'h0F}, 4)
                         : ebp_tb_pkg::crc8(ad[7:0], {24'h000000, d}, 1);
        e.crcDevice = fst ? ebp_tb_pkg::crc8(8'h00, {d, da, st ? 8'h55 : 8'h0F}, 4) : e.crcLocal;
        e.crcDevice = badCrc ? ~e.crcDevice : e.crcDevice;
        e.crcOk = (e.crcDevice == e.crcLocal);
        e.verify = (st ? statShadow[ad[2:0]] : dataShadow[ad[6:0]]) & d;
        e.verifyOk = 1'b1;
        e.noPresence = absent;
        if (e.crcOk && !absent && st) statShadow[ad[2:0]] = e.verify;
        if (e.crcOk && !absent && !st) dataShadow[ad[6:0]] = e.verify;
        expQ.push_back(e);
        modeQ.push_back(absent ? 2 : (e.crcOk ? 0 : 1));
    endtask : expect_res

    task automatic drain();
        while (expQ.size() != 0) @(posedge clk);
        #2;
    endtask : drain

    task automatic run_job(input logic st, input logic [15:0] ad, input logic [7:0] d, input logic fst);
        expect_res(st, ad, d, fst);
        job = '{status: st, address: ad, data: d, first: fst};
        jobValid = 1'b1;
        do @(posedge clk); while (jobReady !== 1'b1);
        #2;
        jobValid = 1'b0;
        drain();
    endtask : run_job

    task automatic check_res(input ebp_pkg::ebp_result_s e, input int m);
        logic bad;
        tests_run++;
        if (m == 0) bad = (result !== e);
        else if (m == 1) bad = ({result.crcDevice, result.crcLocal, result.crcOk} !== {e.crcDevice, e.crcLocal, e.crcOk});
        else bad = (result.noPresence !== 1'b1);
        if (bad) begin
            err_count++;
            $display("Error at %0t: result %h expected %h", $time, result, e);
        end
    endtask : check_res

    task automatic wrap_up();
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // Result watcher and hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > LIMIT) begin
            err_count++;
            wrap_up();
        end
        if (resValid === 1'b1 && expQ.size() == 0) begin
            err_count++;
            $display("Error at %0t: unexpected result", $time);
        end
        else if (resValid === 1'b1) check_res(expQ.pop_front(), modeQ.pop_front());
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        jobValid = 1'b0;
        job = '0;
        badCrc = 1'b0;
        absent = 1'b0;
        foreach (dataShadow[i]) dataShadow[i] = 8'hFF;
        foreach (statShadow[i]) statShadow[i] = (i == 7) ? 8'h00 : 8'hFF;
        repeat (2) @(posedge clk);
        #2;
        rst = 1'b0;
        run_job(1'b0, 16'h0010, rnd(), 1'b1);
        for (int i = 1; i < 3; i++) run_job(1'b0, 16'h0010 + i[15:0], rnd(), 1'b0);
        run_job(1'b0, 16'h0010, rnd(), 1'b1);
        run_job(1'b1, 16'h0006, rnd(), 1'b1);
        run_job(1'b1, 16'h0007, 8'hFF, 1'b0);
        badCrc = 1'b1;
        run_job(1'b1, 16'h0000, rnd(), 1'b1);
        badCrc = 1'b0;
        expect_res(1'b1, 16'h0000, job.data, 1'b1);
        drain();
        run_job(1'b0, 16'h0085, rnd(), 1'b1);
        absent = 1'b1;
        expect_res(1'b0, 16'h0085, job.data, 1'b1);
        drain();
        absent = 1'b0;
        wrap_up();
    end

endmodule : test_ebp_sequencer
